// *** rtl/kbm_ports.sv ***
// Keyboard and mouse serial ports behind an APB register window
`timescale 1ns/1ns
`default_nettype none
module kbm_ports #(
   parameter int INHIBIT_CYCLES = kbm_pkg::INHIBIT_CYC,
   parameter int TIMEOUT_CYCLES = kbm_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [kbm_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Link lines, index 0 keyboard, 1 mouse; outputs only ever pull low
   input wire logic [1:0] LINK_CLK_IN,
   output logic [1:0] LINK_CLK_OUT,
   output logic [1:0] LINK_CLK_OE,
   input wire logic [1:0] LINK_DAT_IN,
   output logic [1:0] LINK_DAT_OUT,
   output logic [1:0] LINK_DAT_OE,
   // System interrupt, one-cycle pulse
   output logic IRQ_PULSE
);
   function automatic logic hit(input logic [1:0] idx, input logic [1:0] want);
      hit = (idx == want);
   endfunction

   wire logic access_done = PSEL & PENABLE & PREADY;
   wire logic wr_done = access_done & PWRITE;
   wire logic rd_done = access_done & ~PWRITE;
   wire logic [1:0] reg_idx = PADDR[3:2]; // [RL2]
   wire logic port_idx = PADDR[kbm_pkg::PORT_SEL_BIT]; // [RL1]

   logic [7:0] rd_val [kbm_pkg::NUM_PORTS];
   logic [1:0] port_irq;
   logic combined;
   logic combined_prev;
   logic [1:0] next_clk_oe;
   logic [1:0] next_dat_oe;

   assign combined = |port_irq; // [RL15]

   // One wait state: ready rises in the second access cycle
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL & PENABLE & ~PREADY;
         PSLVERR <= 1'b0;
         if (PSEL & PENABLE & ~PREADY) begin
            PRDATA <= {24'h00_0000, rd_val[port_idx]};
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         combined_prev <= 1'b0;
         IRQ_PULSE <= 1'b0;
         LINK_CLK_OE <= 2'b00;
         LINK_DAT_OE <= 2'b00;
         LINK_CLK_OUT <= 2'b00;
         LINK_DAT_OUT <= 2'b00;
      end else begin
         combined_prev <= combined;
         IRQ_PULSE <= combined & ~combined_prev; // [RL16]
         LINK_CLK_OE <= next_clk_oe;
         LINK_DAT_OE <= next_dat_oe;
         LINK_CLK_OUT <= 2'b00;
         LINK_DAT_OUT <= 2'b00;
      end
   end

   genvar g;
   generate
      for (g = 0; g < kbm_pkg::NUM_PORTS; g++) begin : port
         wire logic mine = (port_idx == 1'(g));
         wire logic soft_rst = wr_done & mine & hit(reg_idx, kbm_pkg::REG_KIND); // [RL4]
         wire logic tx_wr = wr_done & mine & hit(reg_idx, kbm_pkg::REG_DATA);
         wire logic ctrl_wr = wr_done & mine & hit(reg_idx, kbm_pkg::REG_CTRL);
         wire logic rx_rd = rd_done & mine & hit(reg_idx, kbm_pkg::REG_DATA);

         logic [7:0] ctrl;
         logic [2:0] clk_sync;
         logic [2:0] dat_sync;
         logic clk_level;
         logic dat_level;
         logic loop_clk;
         logic [7:0] loop_cnt;
         logic eff_prev;
         logic [7:0] rx_mem [kbm_pkg::RX_DEPTH];
         logic [1:0] wr_ptr;
         logic [1:0] rd_ptr;
         logic [2:0] rx_count;
         logic [3:0] rx_bits;
         logic [9:0] rx_shift;
         logic [7:0] tx_hold;
         logic tx_full;
         logic [9:0] tx_shift;
         logic [3:0] tx_bits;
         logic tx_dat;
         kbm_pkg::kbm_tx_t tx_state;
         logic [19:0] timer;
         logic parity_err;
         logic timeout_err;

         wire logic loopback = ctrl[kbm_pkg::CB_LOOP];
         wire logic override = ctrl[kbm_pkg::CB_OVERRIDE];
         wire logic enabled = ctrl[kbm_pkg::CB_ENABLE];
         // Loopback feeds the receiver from the transmitter on the internal clock
         wire logic eff_clk = loopback ? loop_clk : clk_level; // [RL12]
         wire logic eff_dat = loopback ? tx_dat : dat_level; // [RL12]
         wire logic fall = eff_prev & ~eff_clk; // [RL24]
         // Receiver shares the lines with the transmitter unless looped back
         wire logic rx_active = loopback | (tx_state == kbm_pkg::TX_IDLE);
         wire logic rx_take = fall & rx_active;
         wire logic [9:0] frame = {eff_dat, rx_shift[9:1]};
         wire logic rx_last = rx_take & (rx_bits == 4'(kbm_pkg::FRAME_BITS - 1)); // [RL23]
         wire logic rx_empty = (rx_count == 3'd0);
         wire logic rx_full = (rx_count == 3'(kbm_pkg::RX_DEPTH));
         wire logic push = rx_last & enabled & ~rx_full; // [RL11]
         wire logic pop = rx_rd & ~rx_empty; // [RL5]
         wire logic bad_parity = ~^frame[8:0]; // [RL24]
         wire logic tx_begin = (tx_state == kbm_pkg::TX_IDLE) & tx_full & (rx_bits == 4'd0) & ~parity_err; // [RL9]
         wire logic tx_last = fall & (tx_state == kbm_pkg::TX_SEND) & (tx_bits == 4'(kbm_pkg::FRAME_BITS - 1));
         wire logic frame_busy = (rx_bits != 4'd0) | (tx_state == kbm_pkg::TX_SEND);
         wire logic timed_out = frame_busy & (timer == 20'(TIMEOUT_CYCLES - 1)); // [RL26]
         wire logic [7:0] status = {dat_level & clk_level & 1'b0 | clk_level, dat_level, 1'b0, combined,
                                    parity_err, timeout_err, tx_full, ~rx_empty}; // [RL6] [RL8] [RL14] [RL15] [RL22]
         wire logic [3:0] kind = (g == 0) ? kbm_pkg::KIND_KBD : kbm_pkg::KIND_MOUSE;

         assign port_irq[g] = enabled & ~rx_empty; // [RL7] [RL10] [RL11]
         assign rd_val[g] = hit(reg_idx, kbm_pkg::REG_KIND) ? {4'h0, kind} : // [RL3]
                            hit(reg_idx, kbm_pkg::REG_DATA) ? rx_mem[rd_ptr] :
                            hit(reg_idx, kbm_pkg::REG_CTRL) ? ctrl : status;
         // Parity error keeps the clock low so the device holds its next character
         assign next_clk_oe[g] = override ? ~ctrl[kbm_pkg::CB_CLK_DRIVE] : // [RL13]
                                 ~loopback & (parity_err | (tx_state == kbm_pkg::TX_INHIBIT) | // [RL17]
                                 (tx_state == kbm_pkg::TX_START)); // [RL25]
         assign next_dat_oe[g] = override ? ~ctrl[kbm_pkg::CB_DAT_DRIVE] : ~loopback & ~tx_dat; // [RL13]

         // Line inputs: a change is taken once the last two stages agree
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               clk_sync <= 3'b111;
               dat_sync <= 3'b111;
               clk_level <= 1'b1;
               dat_level <= 1'b1;
            end else begin
               clk_sync <= {clk_sync[1:0], LINK_CLK_IN[g]};
               dat_sync <= {dat_sync[1:0], LINK_DAT_IN[g]};
               if (clk_sync[1] == clk_sync[2]) begin
                  clk_level <= clk_sync[2];
               end
               if (dat_sync[1] == dat_sync[2]) begin
                  dat_level <= dat_sync[2];
               end
            end
         end

         // Internal loopback clock, halted high outside loopback
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               loop_cnt <= 8'h00;
               loop_clk <= 1'b1;
               eff_prev <= 1'b1;
            end else begin
               eff_prev <= eff_clk;
               if (!loopback || soft_rst) begin
                  loop_cnt <= 8'h00;
                  loop_clk <= 1'b1;
               end else if (loop_cnt == 8'(kbm_pkg::LOOP_HALF_CYC - 1)) begin
                  loop_cnt <= 8'h00;
                  loop_clk <= ~loop_clk; // [RL12]
               end else begin
                  loop_cnt <= loop_cnt + 8'h01;
               end
            end
         end

         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               ctrl <= kbm_pkg::CTRL_RESET; // [RL11]
            end else if (soft_rst) begin
               ctrl <= kbm_pkg::CTRL_RESET; // [RL4]
            end else if (ctrl_wr) begin
               ctrl <= PWDATA[7:0] & 8'hE3; // [RL22]
            end
         end

         // Receive buffer; when full a new character is dropped
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               wr_ptr <= 2'd0;
               rd_ptr <= 2'd0;
               rx_count <= 3'd0;
            end else if (soft_rst) begin
               wr_ptr <= 2'd0;
               rd_ptr <= 2'd0;
               rx_count <= 3'd0;
            end else begin
               if (push) begin
                  wr_ptr <= wr_ptr + 2'd1;
               end
               if (pop) begin
                  rd_ptr <= rd_ptr + 2'd1; // [RL5]
               end
               rx_count <= rx_count + 3'(push) - 3'(pop);
            end
         end

         always_ff @(posedge REF_CLK) begin
            if (push) begin
               rx_mem[wr_ptr] <= frame[7:0]; // [RL17]
            end
         end

         // Receiver: start bit, then data, parity and stop
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               rx_bits <= 4'd0;
               rx_shift <= 10'h000;
               parity_err <= 1'b0;
            end else if (soft_rst || timed_out) begin
               rx_bits <= 4'd0;
               parity_err <= soft_rst ? 1'b0 : parity_err;
            end else if (rx_take) begin
               rx_shift <= frame;
               if (rx_bits == 4'd0) begin
                  rx_bits <= eff_dat ? 4'd0 : 4'd1;
               end else if (rx_last) begin
                  rx_bits <= 4'd0;
                  if (push && bad_parity) begin
                     parity_err <= 1'b1; // [RL17]
                  end
               end else begin
                  rx_bits <= rx_bits + 4'd1;
               end
            end
         end

         // Transmit buffer; a write while it is full is ignored
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               tx_hold <= 8'h00;
               tx_full <= 1'b0;
            end else if (soft_rst) begin
               tx_full <= 1'b0;
            end else if (tx_wr && !tx_full) begin
               tx_hold <= PWDATA[7:0]; // [RL8]
               tx_full <= 1'b1;
            end else if (tx_last || (timed_out && tx_state == kbm_pkg::TX_SEND)) begin
               tx_full <= 1'b0;
            end
         end

         // Transmitter: inhibit, request, then shift on each falling edge
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               tx_state <= kbm_pkg::TX_IDLE;
               tx_shift <= 10'h3FF;
               tx_bits <= 4'd0;
               tx_dat <= 1'b1;
            end else if (soft_rst || timed_out) begin
               tx_state <= kbm_pkg::TX_IDLE;
               tx_dat <= 1'b1;
            end else begin
               unique case (tx_state)
                  kbm_pkg::TX_IDLE: begin
                     tx_dat <= 1'b1;
                     if (tx_begin) begin
                        tx_state <= kbm_pkg::TX_INHIBIT; // [RL25]
                        tx_shift <= {1'b1, ~^tx_hold, tx_hold}; // [RL24]
                        tx_bits <= 4'd0;
                     end
                  end
                  kbm_pkg::TX_INHIBIT: begin
                     if (timer == 20'(INHIBIT_CYCLES - 1)) begin
                        tx_state <= kbm_pkg::TX_START;
                        tx_dat <= 1'b0; // [RL25]
                     end
                  end
                  kbm_pkg::TX_START: begin
                     tx_state <= kbm_pkg::TX_SEND;
                  end
                  kbm_pkg::TX_SEND: begin
                     if (fall) begin
                        tx_bits <= tx_bits + 4'd1;
                        tx_dat <= tx_shift[0];
                        tx_shift <= {1'b1, tx_shift[9:1]};
                        if (tx_last) begin
                           tx_state <= kbm_pkg::TX_IDLE;
                           tx_dat <= 1'b1;
                        end
                     end
                  end
               endcase
            end
         end

         // Shared timer: inhibit length, and stall watch during a frame
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               timer <= 20'd0;
               timeout_err <= 1'b0;
            end else if (soft_rst) begin
               timer <= 20'd0;
               timeout_err <= 1'b0;
            end else begin
               if (timed_out) begin
                  timeout_err <= 1'b1; // [RL26]
               end
               if (fall || tx_begin || timed_out || tx_state == kbm_pkg::TX_START ||
                   (tx_state == kbm_pkg::TX_IDLE && rx_bits == 4'd0)) begin
                  timer <= 20'd0;
               end else begin
                  timer <= timer + 20'd1;
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** rtl/kbm_pkg.sv ***
// Constants and types shared by the keyboard/mouse serial port block
// Function
// [RL1] Two identical ports; keyboard slot at 0x000, mouse slot at 0x100, 256 bytes each.
// [RL2] Byte registers on word boundaries, aliased through the whole 4K window.
// [RL3] Offset 0x00 reads the port type code: 0 keyboard, 1 mouse.
// [RL4] Write to offset 0x00 empties buffers, resets machines, disables port.
// [RL5] Four-character receive buffer; each data read removes one character.
// [RL6] Status bit 0 shows receive buffer holds a character.
// [RL7] Port interrupt high from empty-to-nonempty until the buffer empties.
// [RL8] One-character transmit buffer; status bit 1 full; writes while full ignored.
// [RL9] Pending transmit waits until an incoming character is complete.
// [RL10] Transmission raises no interrupt of its own.
// [RL11] Control bit 0 enables receive and interrupt; control resets to zero.
// [RL12] Control bit 1 loops transmitter to receiver on internal 2 MHz clock.
// [RL13] Control bit 5 lets bits 6 and 7 drive data and clock lines.
// [RL14] Status bits 6 and 7 mirror data and clock line levels.
// [RL15] Port interrupts ORed; the result reads as status bit 4 of both.
// [RL16] One system interrupt on each rising edge of the combined signal.
// [RL17] Parity error sets a sticky flag, stores the character, holds device busy.
// [RL18] Host drains both ports until the combined bit reads zero.
// [RL19] Host writes a new character only after transmit-full clears.
// [RL20] After parity error host drains, resets port, may request resend.
// [RL21] Host resets the external device by an explicit command.
// [RL22] Timeout flag is status bit 2; other listed bits are reserved.
// [RL23] Each character is an 11-bit serial frame, about 80 us per bit.
// [RL24] Frame: start low, eight data LSB first, odd parity, stop high.
// [RL25] Transmit: clock low 100 us, data low, release clock, device clocks.
// [RL26] Timeout flag sets when the device stalls a frame; cleared by reset.
package kbm_pkg;
   localparam int NUM_PORTS = 2;
   localparam int ADDR_W = 12;
   localparam int PORT_SEL_BIT = 8;
   // Register indices within a slot (byte offset bits 3:2)
   localparam logic [1:0] REG_KIND = 2'h0;
   localparam logic [1:0] REG_DATA = 2'h1;
   localparam logic [1:0] REG_CTRL = 2'h2;
   localparam logic [1:0] REG_STAT = 2'h3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] KIND_KBD = 4'h0;
   localparam logic [3:0] KIND_MOUSE = 4'h1;
   // Control bit positions
   localparam int CB_ENABLE = 0;
   localparam int CB_LOOP = 1;
   localparam int CB_OVERRIDE = 5;
   localparam int CB_DAT_DRIVE = 6;
   localparam int CB_CLK_DRIVE = 7;
   // Status bit positions
   localparam int SB_RXNE = 0;
   localparam int SB_TXNE = 1;
   localparam int SB_TIMEOUT = 2;
   localparam int SB_PARITY = 3;
   localparam int SB_COMBINED = 4;
   localparam int SB_DAT = 6;
   localparam int SB_CLK = 7;
   localparam int RX_DEPTH = 4;
   localparam int FRAME_BITS = 11;
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int CLK_NS = 4;
   localparam int INHIBIT_US = 100;
   localparam int INHIBIT_CYC = INHIBIT_US * CLK_MHZ;
   localparam int TIMEOUT_US = 2000;
   localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
   localparam int LOOP_HALF_NS = 250;
   localparam int LOOP_HALF_CYC = LOOP_HALF_NS / CLK_NS;
   typedef enum logic [2:0] {TX_IDLE, TX_INHIBIT, TX_START, TX_SEND} kbm_tx_t;
endpackage

// *** dv/kbm_ports_chk.sv ***
// Port-level assertions for the keyboard/mouse serial port block
`timescale 1ns/1ns
`default_nettype none
module kbm_ports_chk #(
   parameter int INHIBIT_CYCLES = kbm_pkg::INHIBIT_CYC,
   parameter int TIMEOUT_CYCLES = kbm_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Link and interrupt
   input wire logic [1:0] LINK_CLK_OUT,
   input wire logic [1:0] LINK_CLK_OE,
   input wire logic [1:0] LINK_DAT_OUT,
   input wire logic [1:0] LINK_DAT_OE,
   input wire logic IRQ_PULSE
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   // Cycles the keyboard clock line has been pulled so far
   int unsigned low_cnt;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST)
         low_cnt <= 0;
      else if (LINK_CLK_OE[0])
         low_cnt <= low_cnt + 1;
      else
         low_cnt <= 0;
   end
   sequence s_start;
      $rose(LINK_DAT_OE[0]) && LINK_CLK_OE[0];
   endsequence
   sequence s_read(logic [1:0] r);
      PREADY && !PWRITE && PADDR[3:2] == r;
   endsequence
   chk_ready_wait: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
      else $error("ready not in second access cycle");
   chk_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   chk_no_error: assert property (!PSLVERR)
      else $error("error response on mapped window");
   chk_kind_code: assert property (s_read(2'h0) |-> PRDATA == {31'h0000_0000, PADDR[8]})
      else $error("wrong port kind code");
   chk_ctrl_reserved: assert property (s_read(2'h2) |-> PRDATA[4:2] == 3'h0 && PRDATA[31:8] == 24'h00_0000)
      else $error("control reserved bits set");
   chk_stat_reserved: assert property (s_read(2'h3) |-> !PRDATA[5] && PRDATA[31:8] == 24'h00_0000)
      else $error("status reserved bit set");
   chk_irq_pulse: assert property (IRQ_PULSE |=> !IRQ_PULSE)
      else $error("system interrupt longer than one cycle");
   chk_open_drain: assert property (LINK_CLK_OUT == 2'h0 && LINK_DAT_OUT == 2'h0)
      else $error("line driven high");
   chk_inhibit_len: assert property (s_start |-> low_cnt >= INHIBIT_CYCLES - 1)
      else $error("clock inhibit too short");
   chk_start_release: assert property (s_start |-> ##[1:3] !LINK_CLK_OE[0])
      else $error("clock not released after start");
endmodule
bind kbm_ports kbm_ports_chk #(.INHIBIT_CYCLES(INHIBIT_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
   .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_CLK_OUT(LINK_CLK_OUT),
   .LINK_CLK_OE(LINK_CLK_OE), .LINK_DAT_OUT(LINK_DAT_OUT), .LINK_DAT_OE(LINK_DAT_OE), .IRQ_PULSE(IRQ_PULSE));
`default_nettype wire

// *** dv/kbm_link_dev.sv ***
// Behavioural keyboard and mouse on the far side of both links
`timescale 1ns/1ns
`default_nettype none
module kbm_link_dev (
   // Line levels and the pulls this model applies
   input wire logic [1:0] clk_lvl,
   input wire logic [1:0] dat_lvl,
   output logic [1:0] clk_pull,
   output logic [1:0] dat_pull
);
   initial begin
      clk_pull = 2'b00;
      dat_pull = 2'b00;
   end
   // Clocks nbits of a frame into the port; the clock stands still outside frames
   task automatic send(input int p, input logic [7:0] b, input bit bad, input int nbits);
      logic [10:0] f;
      f = {1'b1, ~^b ^ bad, b, 1'b0};
      // Step off the clock edge so line changes do not race the port's sampling flops when the call starts on an edge
      #1;
      for (int i = 0; i < nbits; i++) begin
         dat_pull[p] = ~f[i];
         #16 clk_pull[p] = 1'b1;
         #16 clk_pull[p] = 1'b0;
      end
      dat_pull[p] = 1'b0;
   endtask
   // Waits for a host request, clocks it in; sampled late since the port reacts through a synchroniser
   task automatic take(input int p, output logic [9:0] got);
      int n;
      n = 0;
      while (!(dat_lvl[p] === 1'b0 && clk_lvl[p] === 1'b1) && n < 20000) begin
         #4 n++;
      end
      // No request seen: hand back an unknown frame so the compare counts a mismatch
      if (n >= 20000) begin
         got = 'x;
         return;
      end
      for (int i = 1; i <= 11; i++) begin
         #16;
         if (i >= 2)
            got[i-2] = dat_lvl[p];
         dat_pull[p] = (i == 11);
         clk_pull[p] = 1'b1;
         #16 clk_pull[p] = 1'b0;
      end
      #16 dat_pull[p] = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** dv/kbm_ports_bench.sv ***
// Self-checking bench for the keyboard/mouse serial ports
`timescale 1ns/1ns
`default_nettype none
module kbm_ports_bench;
   logic REF_CLK = 0;
   logic RST = 1;
   logic PSEL = 0;
   logic PENABLE = 0;
   logic PWRITE = 0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, IRQ_PULSE;
   logic [1:0] clk_oe, clk_out, dat_oe, dat_out, m_clk, m_dat, clk_lvl, dat_lvl;
   logic [1:0] en = 2'b00;
   logic [7:0] rxq[2][$];
   int failures = 0;
   int n_compared = 0;
   int irqs = 0;
   always #2 REF_CLK = ~REF_CLK;
   // Open-drain lines with pull-ups
   assign clk_lvl = ~(clk_oe | m_clk);
   assign dat_lvl = ~(dat_oe | m_dat);
   always @(posedge REF_CLK) if (IRQ_PULSE === 1'b1) irqs <= irqs + 1;
   kbm_ports #(.INHIBIT_CYCLES(20), .TIMEOUT_CYCLES(2000)) dut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .LINK_CLK_IN(clk_lvl), .LINK_CLK_OUT(clk_out), .LINK_CLK_OE(clk_oe),
      .LINK_DAT_IN(dat_lvl), .LINK_DAT_OUT(dat_out), .LINK_DAT_OE(dat_oe), .IRQ_PULSE(IRQ_PULSE));
   kbm_link_dev dev (.clk_lvl(clk_lvl), .dat_lvl(dat_lvl), .clk_pull(m_clk), .dat_pull(m_dat));
   task automatic close_out();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_lnk(input logic [9:0] got, input logic [9:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request stands until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
      int n;
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {24'h00_0000, d};
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      r = PRDATA[7:0];
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n >= 50) begin
         failures++;
         close_out();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] x;
      apb(1'b1, a, d, x);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
      logic [7:0] x;
      apb(1'b0, a, 8'h00, x);
      cmp_reg(x & m, exp & m);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask
   // Reference receive buffer: disabled ports and full buffers drop characters
   task automatic push(input int p, input logic [7:0] b);
      if (en[p] && rxq[p].size() < 4)
         rxq[p].push_back(b);
   endtask
   function automatic logic [7:0] st(input int p, input bit tx, input bit par, input bit to);
      logic c;
      c = (en[0] && rxq[0].size() > 0) || (en[1] && rxq[1].size() > 0);
      return {2'b11, 1'b0, c, par, to, tx, rxq[p].size() > 0};
   endfunction
   initial begin
      logic [7:0] b;
      logic [7:0] rv;
      logic [9:0] f;
      int n;
      void'($urandom(39));
      repeat (12) @(posedge REF_CLK);
      RST <= 1'b0;
      idle(4);
      for (int p = 0; p < 2; p++) begin
         rdc(12'(p * 256), 8'(p));
         rdc(12'(p * 256 + 8), 8'h00);
         rdc(12'(p * 256 + 12), st(p, 0, 0, 0));
      end
      rdc(12'h7f0, 8'h01);
      dev.send(0, 8'h5a, 0, 11);
      idle(10);
      rdc(12'h00c, st(0, 0, 0, 0));
      wr(12'h008, 8'h01);
      wr(12'h108, 8'h01);
      en = 2'b11;
      for (int i = 0; i < 6; i++) begin
         b = 8'($urandom);
         dev.send(i / 5, b, 0, 11);
         push(i / 5, b);
      end
      idle(10);
      cmp_lnk(10'(irqs), 10'd1);
      rdc(12'h10c, st(1, 0, 0, 0));
      for (int p = 0; p < 2; p++)
         while (rxq[p].size() > 0) rdc(12'(p * 256 + 4), rxq[p].pop_front());
      rdc(12'h00c, st(0, 0, 0, 0));
      dev.send(1, 8'ha5, 0, 11);
      push(1, 8'ha5);
      idle(10);
      cmp_lnk(10'(irqs), 10'd2);
      rdc(12'h104, rxq[1].pop_front());
      b = 8'($urandom);
      fork
         dev.send(0, 8'h3c, 0, 11);
         begin
            // Land the write well inside the frame, past the synchroniser delay of the start bit
            idle(20);
            wr(12'h004, b);
            wr(12'h004, ~b);
            rdc(12'h00c, st(0, 1, 0, 0), 8'h3f);
         end
      join
      push(0, 8'h3c);
      dev.take(0, f);
      cmp_lnk(f, {1'b1, ~^b, b});
      idle(10);
      rdc(12'h00c, st(0, 0, 0, 0));
      rdc(12'h004, rxq[0].pop_front());
      dev.send(0, 8'h81, 1, 11);
      push(0, 8'h81);
      idle(10);
      rdc(12'h00c, st(0, 0, 1, 0) & 8'h7f);
      cmp_lnk(10'(clk_oe), 10'd1);
      wr(12'h000, 8'hff);
      rxq[0].delete();
      en[0] = 1'b0;
      idle(10);
      rdc(12'h00c, st(0, 0, 0, 0));
      rdc(12'h008, 8'h00);
      dev.send(1, 8'h00, 0, 4);
      idle(2100);
      rdc(12'h10c, st(1, 0, 0, 1));
      wr(12'h100, 8'h00);
      en[1] = 1'b0;
      idle(4);
      rdc(12'h10c, st(1, 0, 0, 0));
      wr(12'h108, 8'h03);
      en[1] = 1'b1;
      b = 8'($urandom);
      wr(12'h104, b);
      n = 0;
      rv = 8'h00;
      while (n < 1000 && rv[0] !== 1'b1) begin
         apb(1'b0, 12'h10c, 8'h00, rv);
         n++;
      end
      if (rv[0] !== 1'b1) begin
         failures++;
         close_out();
      end
      rdc(12'h104, b);
      cmp_lnk(10'({clk_oe, dat_oe}), 10'd0);
      for (int i = 0; i < 2; i++) begin
         wr(12'h008, i ? 8'h60 : 8'ha0);
         idle(6);
         cmp_lnk(10'({clk_oe[0], dat_oe[0]}), i ? 10'd2 : 10'd1);
         rdc(12'h00c, i ? 8'h40 : 8'h80);
      end
      // Alias of the keyboard control register: address bit 8 clear, upper bits set
      wr(12'hef8, 8'hff);
      rdc(12'h008, 8'he3);
      idle(6);
      cmp_lnk(10'({clk_oe[0], dat_oe[0]}), 10'd0);
      close_out();
   end
   initial begin
      #300000;
      failures++;
      close_out();
   end
endmodule
`default_nettype wire
